// ==== hdl/bfc_bus_if.sv ====
// Carrier between the host sequencer and the pin cycle engine.
// Assumes both ends run on the same clock.
`default_nettype none
interface bfc_bus_if;
  logic        req;
  logic        wr;
  logic        hv;
  logic [17:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  dq_in;
  logic        done;
  logic [7:0]  rdata;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [17:0] pin_addr;
  logic [7:0]  dq_out;
  logic        dq_oe;
  logic        hv_id;
  modport ctrl (output req, wr, hv, addr, wdata, dq_in,
                input done, rdata, ce_n, oe_n, we_n, pin_addr, dq_out,
                dq_oe, hv_id);
  modport eng (input req, wr, hv, addr, wdata, dq_in,
               output done, rdata, ce_n, oe_n, we_n, pin_addr, dq_out,
               dq_oe, hv_id);
endinterface
`default_nettype wire

// ==== hdl/bfc_cycle.sv ====
// Pin cycle engine: one flash write or read cycle per request.
// Assumes req is a one-cycle pulse given only while idle.
`default_nettype none
module bfc_cycle
  import bfc_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic RESET,
  bfc_bus_if.eng    bus
);
  typedef enum logic [1:0] {
    CY_IDLE  = 2'b00,
    CY_PULSE = 2'b01,
    CY_RECOV = 2'b11
  } bfc_cy_e;
  typedef struct packed {
    bfc_cy_e     st;
    logic        wr;
    logic [5:0]  cnt;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [17:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
    logic        hv;
    logic [7:0]  rdata;
    logic        done;
  } bfc_cy_s;
  bfc_cy_s q, n;

  always_comb
  begin
    n = q;
    n.done = 1'b0;
    unique case (q.st)
      CY_IDLE:
        if (bus.req)
        begin
          n.wr   = bus.wr;
          n.addr = bus.addr;                       // R3
          n.hv   = bus.hv;                         // R20
          n.ce_n = 1'b0;
          if (bus.wr)
          begin
            n.dq_out = bus.wdata;
            n.dq_oe  = 1'b1;
            n.we_n   = 1'b0;                       // R1
            n.cnt    = WP_CYC - 6'h01;
          end
          else
          begin
            n.oe_n = 1'b0;                         // R6
            n.cnt  = ACC_CYC - 6'h01;
          end
          n.st = CY_PULSE;
        end
      CY_PULSE:
        if (q.cnt != 6'h00)
          n.cnt = q.cnt - 6'h01;
        else if (q.wr)
        begin
          // Rising write strobe latches the byte; address and data hold
          n.we_n = 1'b1;                           // R1
          n.cnt  = WREC_CYC - 6'h01;
          n.st   = CY_RECOV;
        end
        else
        begin
          n.rdata = bus.dq_in;
          // Releasing both makes the next read relatch status
          n.oe_n  = 1'b1;                          // R8
          n.ce_n  = 1'b1;                          // R22
          n.cnt   = DF_CYC - 6'h01;
          n.st    = CY_RECOV;
        end
      CY_RECOV:
        if (q.cnt != 6'h00)
          n.cnt = q.cnt - 6'h01;
        else
        begin
          n.ce_n  = 1'b1;
          n.dq_oe = 1'b0;
          n.hv    = 1'b0;
          n.done  = 1'b1;
          n.st    = CY_IDLE;
        end
      default:
        n.st = CY_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      q      <= '0;
      q.st   <= CY_IDLE;
      q.ce_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
    end
    else
      q <= n;
  end

  assign bus.done     = q.done;
  assign bus.rdata    = q.rdata;
  assign bus.ce_n     = q.ce_n;
  assign bus.oe_n     = q.oe_n;
  assign bus.we_n     = q.we_n;
  assign bus.pin_addr = q.addr;
  assign bus.dq_out   = q.dq_out;
  assign bus.dq_oe    = q.dq_oe;
  assign bus.hv_id    = q.hv;
endmodule
`default_nettype wire

// ==== hdl/bfc_host.sv ====
// Host controller for a byte-wide boot-block flash: software orders
// operations through a small register port, the block runs the pin
// sequences and polls device status.
// Assumes the flash pins are sampled synchronously to CLOCK.
//
// Summary of operation
// R1: Commands are one or two strobed writes
// R2: Commands only act with program supply high
// R3: Every write carries address and data
// R4: Write FF returns device to array read
// R5: Power-up and wake give array read
// R6: Read: select, output enable low, strobes high
// R7: Write 70 makes reads return status
// R8: Toggle enables between reads to refresh status
// R9: Fail flags cleared only by 50
// R10: Host clears low-voltage flag before program/erase
// R11: Erase is 20 then D0 in block
// R12: Erase needs program supply high
// R13: After erase poll status until ready
// R14: Erase fail flag reports result when ready
// R15: B0 asks erase to pause
// R16: Paused when ready and suspend both set
// R17: While paused only array and status reads; the block also lets clear (50) through
// R18: D0 while paused resumes the erase
// R19: 90 enters identification; 0 maker, 1 part
// R20: High voltage on line nine reads identification
// R21: Identification stays until another command
// R22: Select high puts device in standby
// R23: Power-down reset low, release gives array
// R24: Program is 40 then address and data
// R25: Status bits: ready, suspend, fails, low-voltage
// R26: Bad confirm sets both fail flags
// R27: During program only status read accepted
`default_nettype none
module bfc_host
  import bfc_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic [7:0]  BUS_ADDR,
  input  wire logic [31:0] BUS_WDATA,
  input  wire logic        BUS_WR,
  input  wire logic        BUS_RD,
  output var  logic [31:0] BUS_RDATA,
  output var  logic        BUSY,
  output var  logic [17:0] FLASH_ADDR,
  input  wire logic [7:0]  FLASH_DQ_IN,
  output var  logic [7:0]  FLASH_DQ_OUT,
  output var  logic        FLASH_DQ_OE,
  output var  logic        FLASH_CE_N,
  output var  logic        FLASH_OE_N,
  output var  logic        FLASH_WE_N,
  output var  logic        FLASH_PDWN_N,
  output var  logic        FLASH_VPP_HIGH,
  output var  logic        FLASH_HV_ID
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WR1  = 3'b001,
    HS_WR2  = 3'b011,
    HS_POLL = 3'b010,
    HS_RD   = 3'b110,
    HS_WAKE = 3'b111
  } bfc_hs_e;

  typedef struct packed {
    bfc_hs_e     st;
    logic [3:0]  op;
    bfc_plan_s   pl;
    logic [17:0] addr;
    logic [7:0]  wdata;
    logic        cfg_vpp;
    logic [5:0]  vpp_cnt;
    logic        pdwn_n;
    logic [5:0]  wake_cnt;
    logic        busy;
    logic        refused;
    logic        lv_pend;
    logic        susp;
    bfc_mode_e   mode;
    logic [7:0]  last_stat;
    logic [7:0]  rd_byte;
    logic        req;
    logic        wr;
    logic        hv;
    logic [17:0] e_addr;
    logic [7:0]  e_wdata;
    logic [31:0] rdata;
  } bfc_host_s;

  bfc_host_s q, n;
  bfc_bus_if bus ();

  bfc_cycle u_cycle (
    .CLOCK (CLOCK),
    .RESET (RESET),
    .bus   (bus)
  );

  // Command sequence of each operation
  function automatic bfc_plan_s op_plan(input logic [3:0] op);
    bfc_plan_s p;
    p = '0;
    p.valid = 1'b1;
    unique case (op)
      OP_READ:    p.post = POST_READ;                      // R6
      OP_ARRAY:
      begin
        p.w1 = 1'b1; p.c1 = CMD_ARRAY;                     // R4
        p.set_mode = 1'b1; p.mode = MODE_ARRAY;
      end
      OP_STATUS:
      begin
        p.w1 = 1'b1; p.c1 = CMD_STATUS; p.post = POST_READ; // R7
        p.set_mode = 1'b1; p.mode = MODE_STATUS;
      end
      OP_CLEAR:   begin p.w1 = 1'b1; p.c1 = CMD_CLEAR; end  // R9
      OP_IDENT:
      begin
        p.w1 = 1'b1; p.c1 = CMD_IDENT; p.post = POST_READ; // R19
        p.set_mode = 1'b1; p.mode = MODE_IDENT;            // R21
      end
      OP_PROGRAM:
      begin
        p.w1 = 1'b1; p.c1 = CMD_PROG;                      // R24
        p.w2 = 1'b1; p.w2_data = 1'b1; p.post = POST_READY;
        p.set_mode = 1'b1; p.mode = MODE_STATUS;
      end
      OP_ERASE:
      begin
        p.w1 = 1'b1; p.c1 = CMD_ERASE;                     // R11
        p.w2 = 1'b1; p.c2 = CMD_CONFIRM; p.post = POST_READY;
        p.set_mode = 1'b1; p.mode = MODE_STATUS;           // R13
      end
      OP_SUSPEND:
      begin
        p.w1 = 1'b1; p.c1 = CMD_SUSPEND; p.post = POST_SUSP; // R15
        p.set_mode = 1'b1; p.mode = MODE_STATUS;
      end
      OP_RESUME:
      begin
        p.w1 = 1'b1; p.c1 = CMD_CONFIRM;                   // R18
        p.set_mode = 1'b1; p.mode = MODE_STATUS;
      end
      OP_SIG_HV:  p.post = POST_READ;                      // R20
      default:    p.valid = 1'b0;
    endcase
    return p;
  endfunction

  // Launch one engine cycle
  function automatic bfc_host_s launch(input bfc_host_s s,
                                       input logic wr,
                                       input logic [7:0] wd);
    bfc_host_s r;
    r = s;
    r.req     = 1'b1;
    r.wr      = wr;
    r.e_wdata = wd;
    r.hv      = !wr && (s.op == OP_SIG_HV);
    // Signature by high voltage needs the other lines low
    r.e_addr  = r.hv ? {17'h0_0000, s.addr[0]} : s.addr;  // R20
    return r;
  endfunction

  // Finish of an operation: record mode and free the block
  function automatic bfc_host_s finish(input bfc_host_s s);
    bfc_host_s r;
    r = s;
    r.busy = 1'b0;
    r.st   = HS_IDLE;
    if (s.pl.set_mode)
      r.mode = s.pl.mode;
    return r;
  endfunction

  // After the command writes, read, poll or finish
  function automatic bfc_host_s after_writes(input bfc_host_s s);
    bfc_host_s r;
    r = s;
    unique case (s.pl.post)
      POST_NONE:
        r = finish(s);
      POST_READ:
      begin
        r = launch(s, 1'b0, 8'h00);
        r.st = HS_RD;
      end
      default:
      begin
        r = launch(s, 1'b0, 8'h00);
        r.st = HS_POLL;                                    // R13
      end
    endcase
    return r;
  endfunction

  logic       ctrl_wr;
  logic [3:0] new_op;
  bfc_plan_s  new_pl;
  logic       needs_vpp;
  logic       vpp_ok;
  logic       deny;

  always_comb
  begin
    ctrl_wr   = BUS_WR && (BUS_ADDR == REG_CTRL);
    new_op    = BUS_WDATA[3:0];
    new_pl    = op_plan(new_op);
    needs_vpp = new_pl.w1;
    vpp_ok    = q.cfg_vpp && (q.vpp_cnt == 6'h00);
    deny      = 1'b0;
    if (!q.pdwn_n && new_op != OP_WAKE)
      deny = 1'b1;                                         // R23
    else if (new_op == OP_SLEEP || new_op == OP_WAKE)
      deny = 1'b0;
    else if (!new_pl.valid)
      deny = 1'b1;
    else if (needs_vpp && !vpp_ok)
      deny = 1'b1;                                         // R2
    else if ((new_op == OP_PROGRAM || new_op == OP_ERASE) && q.lv_pend)
      deny = 1'b1;                                         // R10
    else if (q.susp && !(new_op == OP_ARRAY || new_op == OP_STATUS ||
                         new_op == OP_RESUME || new_op == OP_READ ||
                         new_op == OP_CLEAR))
      deny = 1'b1;                                         // R17
  end

  always_comb
  begin
    n = q;
    n.req   = 1'b0;
    n.rdata = 32'h0000_0000;
    // Supply must settle before a strobe edge relies on it
    if (!q.cfg_vpp)
      n.vpp_cnt = VPS_CYC;                                 // R12
    else if (q.vpp_cnt != 6'h00)
      n.vpp_cnt = q.vpp_cnt - 6'h01;
    if (BUS_WR)
    begin
      unique case (BUS_ADDR)
        REG_ADDR: n.addr    = BUS_WDATA[17:0];
        REG_DATA: n.wdata   = BUS_WDATA[7:0];
        REG_CFG:  n.cfg_vpp = BUS_WDATA[CFG_VPP_BIT];
        default:  n.cfg_vpp = q.cfg_vpp;
      endcase
    end
    if (BUS_RD)
    begin
      unique case (BUS_ADDR)
        REG_CTRL: n.rdata = {28'h000_0000, q.op};
        REG_ADDR: n.rdata = {14'h0000, q.addr};
        REG_DATA: n.rdata = {24'h00_0000, q.rd_byte};
        REG_STAT: n.rdata = {16'h0000, q.last_stat, 1'b0, q.mode,
                             q.susp, !q.pdwn_n, q.lv_pend, q.refused,
                             q.busy};
        REG_CFG:  n.rdata = {31'h0000_0000, q.cfg_vpp};
        default:  n.rdata = 32'h0000_0000;
      endcase
    end
    // Orders while busy are dropped; the host polls status meanwhile
    if (ctrl_wr && q.busy)
      n.refused = 1'b1;                                    // R27
    unique case (q.st)
      HS_IDLE:
        if (ctrl_wr)
        begin
          n.op      = new_op;
          n.pl      = new_pl;
          n.refused = deny;
          if (!deny)
          begin
            if (new_op == OP_SLEEP)
            begin
              n.pdwn_n = 1'b0;                             // R23
              n.susp = 1'b0;
            end
            else if (new_op == OP_WAKE)
            begin
              n.pdwn_n   = 1'b1;
              n.wake_cnt = WAKE_CYC;
              n.busy     = 1'b1;
              n.st       = HS_WAKE;
            end
            else
            begin
              n.busy = 1'b1;
              if (new_op == OP_RESUME)
                n.susp = 1'b0;                             // R18
              if (new_op == OP_CLEAR)
                n.lv_pend = 1'b0;                          // R9
              if (new_pl.w1)
              begin
                n = launch(n, 1'b1, new_pl.c1);            // R1
                n.st = HS_WR1;
              end
              else
                n = after_writes(n);
            end
          end
        end
      HS_WR1:
        if (bus.done)
        begin
          if (q.pl.w2)
          begin
            n = launch(n, 1'b1,
                       q.pl.w2_data ? q.wdata : q.pl.c2);  // R24
            n.st = HS_WR2;
          end
          else
            n = after_writes(n);
        end
      HS_WR2:
        if (bus.done)
          n = after_writes(n);
      HS_RD:
        if (bus.done)
        begin
          n.rd_byte = bus.rdata;
          if (q.op == OP_STATUS)
            n.last_stat = bus.rdata;                       // R7
          n = finish(n);
        end
      HS_POLL:
        if (bus.done)
        begin
          n.last_stat = bus.rdata;                         // R25
          n.rd_byte   = bus.rdata;
          // Ready alone ends a suspend: the erase may end first
          if (bus.rdata[ST_READY])
          begin
            // Fail flags stay in last_stat until the next status read or poll
            n.lv_pend = q.lv_pend || bus.rdata[ST_LOWV];   // R14
            n.susp    = (q.pl.post == POST_SUSP) && bus.rdata[ST_SUSP]; // R16
            n = finish(n);
          end
          else
            n = launch(n, 1'b0, 8'h00);                    // R8
        end
      HS_WAKE:
        if (q.wake_cnt != 6'h00)
          n.wake_cnt = q.wake_cnt - 6'h01;
        else
        begin
          n.mode = MODE_ARRAY;                             // R5
          n.busy = 1'b0;
          n.st   = HS_IDLE;
        end
      default:
        n.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      q          <= '0;
      q.st       <= HS_WAKE;
      q.pdwn_n   <= 1'b1;
      q.wake_cnt <= WAKE_CYC;
      q.busy     <= 1'b1;
      q.mode     <= MODE_ARRAY;
      q.vpp_cnt  <= VPS_CYC;
    end
    else
      q <= n;
  end

  assign bus.req   = q.req;
  assign bus.wr    = q.wr;
  assign bus.hv    = q.hv;
  assign bus.addr  = q.e_addr;
  assign bus.wdata = q.e_wdata;
  assign bus.dq_in = FLASH_DQ_IN;

  assign BUS_RDATA      = q.rdata;
  assign BUSY           = q.busy;
  assign FLASH_ADDR     = bus.pin_addr;
  assign FLASH_DQ_OUT   = bus.dq_out;
  assign FLASH_DQ_OE    = bus.dq_oe;
  assign FLASH_CE_N     = bus.ce_n;                        // R22
  assign FLASH_OE_N     = bus.oe_n;
  assign FLASH_WE_N     = bus.we_n;
  assign FLASH_PDWN_N   = q.pdwn_n;
  assign FLASH_VPP_HIGH = q.cfg_vpp;                       // R2
  assign FLASH_HV_ID    = bus.hv_id;
endmodule
`default_nettype wire

// ==== hdl/bfc_pkg.sv ====
// Constants, plan record and types for the boot flash host controller.
// Assumes a 100 MHz CLOCK; all pin timings are derived from it.
`default_nettype none
package bfc_pkg;
  localparam int CLK_NS = 10;
  function automatic int ns2cyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  // Pin timing minimums in ns, and the derived cycle counts
  localparam int T_WP_NS   = 50;
  localparam int T_WC_NS   = 90;
  localparam int T_ACC_NS  = 150;
  localparam int T_DF_NS   = 30;
  localparam int T_PHQV_NS = 300;
  localparam int T_VPS_NS  = 100;
  localparam logic [5:0] WP_CYC   = 6'(ns2cyc(T_WP_NS));
  localparam logic [5:0] WREC_CYC = 6'(ns2cyc(T_WC_NS - T_WP_NS));
  localparam logic [5:0] ACC_CYC  = 6'(ns2cyc(T_ACC_NS));
  localparam logic [5:0] DF_CYC   = 6'(ns2cyc(T_DF_NS));
  localparam logic [5:0] WAKE_CYC = 6'(ns2cyc(T_PHQV_NS));
  localparam logic [5:0] VPS_CYC  = 6'(ns2cyc(T_VPS_NS));
  // Own register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_CFG  = 8'h10;
  localparam int CFG_VPP_BIT = 0;
  // Device command bytes
  localparam logic [7:0] CMD_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_PROG    = 8'h40;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR   = 8'h50;
  localparam logic [7:0] CMD_ERASE   = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_IDENT   = 8'h90;
  // Device status bit positions
  localparam int ST_READY = 7;
  localparam int ST_SUSP  = 6;
  localparam int ST_EFAIL = 5;
  localparam int ST_PFAIL = 4;
  localparam int ST_LOWV  = 3;
  // Operation codes written to REG_CTRL
  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_ARRAY   = 4'h1;
  localparam logic [3:0] OP_STATUS  = 4'h2;
  localparam logic [3:0] OP_CLEAR   = 4'h3;
  localparam logic [3:0] OP_IDENT   = 4'h4;
  localparam logic [3:0] OP_PROGRAM = 4'h5;
  localparam logic [3:0] OP_ERASE   = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME  = 4'h8;
  localparam logic [3:0] OP_SIG_HV  = 4'h9;
  localparam logic [3:0] OP_SLEEP   = 4'hA;
  localparam logic [3:0] OP_WAKE    = 4'hB;

  typedef enum logic [1:0] {
    POST_NONE  = 2'b00,
    POST_READ  = 2'b01,
    POST_READY = 2'b11,
    POST_SUSP  = 2'b10
  } bfc_post_e;
  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_STATUS = 2'b01,
    MODE_IDENT  = 2'b11
  } bfc_mode_e;
  typedef struct packed {
    logic       valid;
    logic       w1;
    logic [7:0] c1;
    logic       w2;
    logic       w2_data;
    logic [7:0] c2;
    bfc_post_e  post;
    logic       set_mode;
    bfc_mode_e  mode;
  } bfc_plan_s;
endpackage
`default_nettype wire

// ==== tb/bfc_flash_model.sv ====
// Behavioural model of the byte-wide flash at the host's pins.
// Assumes pins change just after clock edges; busy time is in clocks.
`default_nettype none
module bfc_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hC3, // Arbitrary value
  parameter int         BUSY_CYC   = 20
)(
  input  wire logic        clock,
  input  wire logic        pdwn_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        vpp_high,
  input  wire logic        hv_id,
  input  wire logic        fail_en,
  input  wire logic [17:0] addr,
  input  wire logic [7:0]  din,
  output var  logic [7:0]  dq
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [1:0] {FM_ARRAY, FM_STAT, FM_IDENT} bfc_fm_mode_e;
  bfc_fm_mode_e mode = FM_ARRAY;
  logic [7:0]   st = 8'h80, st_lat = 8'h80, setup = 8'h00;
  logic [7:0]   val, last = 8'h00, pd = 8'hFF;
  logic [17:0]  pa = 18'h0_0000;
  logic         we_q = 1'h1, rd_q = 1'h0, erasing = 1'h0, rd;
  int           cnt = 0;
  assign rd = pdwn_n && !ce_n && !oe_n && we_n;
  always_comb
  begin
    if (mode == FM_STAT) val = st_lat;
    else if (mode == FM_IDENT || hv_id)
      val = addr[0] ? PART_CODE : MAKER_CODE;
    else val = (addr == pa) ? pd : addr[7:0] ^ 8'hA5;
  end
  // Released bus shows the inverse byte so a stale value cannot pass
  assign dq = rd ? val : ~last;
  always @(posedge clock)
  begin
    we_q <= we_n;
    rd_q <= rd;
    if (rd) last <= val;
    if (rd && !rd_q) st_lat <= st;
    if (!pdwn_n)
    begin
      mode <= FM_ARRAY;
      setup <= 8'h00;
      st[7:6] <= 2'h2;
    end
    else if (we_n && !we_q && !ce_n && vpp_high)
    begin
      setup <= 8'h00;
      if (setup != 8'h00)
      begin
        mode <= FM_STAT;
        erasing <= (setup == 8'h20);
        if (setup == 8'h20 && din != 8'hD0) st[5:4] <= 2'h3;
        else
        begin
          st[7] <= 1'h0;
          cnt <= BUSY_CYC;
        end
        if (setup == 8'h40)
        begin
          pa <= addr;
          pd <= din;
        end
      end
      else if (!st[7] || st[6])
      begin
        if (din == 8'h70) mode <= FM_STAT;
        if (din == 8'hFF && st[6]) mode <= FM_ARRAY;
        if (din == 8'hB0 && erasing && !st[7]) st[7:6] <= 2'h3;
        if (din == 8'hD0 && st[6]) st[7:6] <= 2'h0;
      end
      else
        case (din)
          8'hFF: mode <= FM_ARRAY;
          8'h70: mode <= FM_STAT;
          8'h50: st[5:3] <= 3'h0;
          8'h90: mode <= FM_IDENT;
          8'h20, 8'h40: setup <= din;
          default: ;
        endcase
    end
    else if (!st[7])
    begin
      if (cnt > 1) cnt <= cnt - 1;
      else
      begin
        st[7] <= 1'h1;
        st[5] <= st[5] | (erasing & fail_en);
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/bfc_host_bench.sv ====
// Self-checking bench: bfc_host driving the flash model.
// Assumes the register map and op codes of bfc_pkg.
`default_nettype none
module bfc_host_bench
  import bfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] PART  = 8'hC3; // Arbitrary value
  logic        clock = 1'h0, reset = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0;
  logic [7:0]  bus_addr = 8'h00, dq_out, dq_dev, dq_in;
  logic [31:0] bus_wdata = 32'h0000_0000, bus_rdata, rv;
  logic        busy, ce_n, oe_n, we_n, pdwn_n, vpp, hv, dq_oe, fail_en = 1'h0;
  logic [17:0] f_addr;
  int          failures = 0, num_checks = 0;
  assign dq_in = dq_oe ? dq_out : dq_dev;
  initial forever #5 clock = ~clock;
  bfc_host uut (.CLOCK(clock), .RESET(reset), .BUS_ADDR(bus_addr),
    .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
    .BUS_RDATA(bus_rdata), .BUSY(busy), .FLASH_ADDR(f_addr),
    .FLASH_DQ_IN(dq_in), .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe),
    .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n),
    .FLASH_PDWN_N(pdwn_n), .FLASH_VPP_HIGH(vpp), .FLASH_HV_ID(hv));
  bfc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BUSY_CYC(20))
    flash (.clock(clock), .pdwn_n(pdwn_n), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .vpp_high(vpp), .hv_id(hv), .fail_en(fail_en),
    .addr(f_addr), .din(dq_out), .dq(dq_dev));
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge clock);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge clock);
    bus_rd <= 1'h0;
    @(negedge clock);
    rv = bus_rdata;
  endtask
  task automatic idle();
    int n;
    n = 0;
    @(negedge clock);
    while (busy !== 1'h0 && n < 4000)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 4000)
    begin
      failures++;
      $display("[FAIL] %0t busy never fell", $time);
      finish_test();
    end
  endtask
  task automatic op(input logic [3:0] o);
    wr(REG_CTRL, {28'h000_0000, o});
    idle();
  endtask
  task automatic t_power_up();
    idle();
    rd(REG_STAT);
    chk(rv[6:0], 7'h00);
    rd(8'h20);
    chk(rv, 32'h0000_0000);
  endtask
  task automatic t_supply();
    op(OP_ARRAY);
    rd(REG_STAT);
    chk(rv[1], 1'h1);
    wr(REG_CFG, 32'h0000_0001);
    rd(REG_CFG);
    chk(rv, 32'h0000_0001);
    repeat (12) @(posedge clock);
  endtask
  task automatic t_ident();
    wr(REG_ADDR, 32'h0000_0000);
    op(OP_IDENT);
    rd(REG_DATA);
    chk(rv[7:0], MAKER);
    wr(REG_ADDR, 32'h0000_0001);
    op(OP_IDENT);
    rd(REG_DATA);
    chk(rv[7:0], PART);
    rd(REG_STAT);
    chk(rv[6:5], 2'h3);
    op(OP_ARRAY);
    op(OP_SIG_HV);
    rd(REG_DATA);
    chk(rv[7:0], PART);
  endtask
  task automatic t_program();
    wr(REG_ADDR, 32'h0001_2345);
    wr(REG_DATA, 32'h0000_003C);
    op(OP_PROGRAM);
    rd(REG_STAT);
    chk({rv[15:8], rv[6:5]}, {8'h80, 2'h1});
    op(OP_ARRAY);
    op(OP_READ);
    rd(REG_DATA);
    chk(rv[7:0], 8'h3C);
  endtask
  task automatic t_erase_fail();
    fail_en <= 1'h1;
    wr(REG_ADDR, 32'h0002_0000);
    rd(REG_ADDR);
    chk(rv, 32'h0002_0000);
    op(OP_ERASE);
    rd(REG_STAT);
    chk(rv[15:8], 8'hA0);
    fail_en <= 1'h0;
    op(OP_STATUS);
    rd(REG_STAT);
    chk(rv[15:8], 8'hA0);
    op(OP_CLEAR);
    op(OP_STATUS);
    rd(REG_STAT);
    chk(rv[15:8], 8'h80);
    op(OP_SUSPEND);
    rd(REG_STAT);
    chk(rv[4], 1'h0);
  endtask
  task automatic t_sleep();
    wr(REG_ADDR, 32'h0000_0010);
    op(OP_IDENT);
    op(OP_SLEEP);
    rd(REG_STAT);
    chk(rv[3], 1'h1);
    op(OP_WAKE);
    rd(REG_STAT);
    chk({rv[6:5], rv[3]}, 3'h0);
    op(OP_READ);
    rd(REG_DATA);
    chk(rv[7:0], 8'hB5);
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    t_power_up();
    t_supply();
    t_ident();
    t_program();
    t_erase_fail();
    t_sleep();
    finish_test();
  end
endmodule
`default_nettype wire

// ==== tb/bfc_host_chk.sv ====
// Assertions on the flash pins of bfc_host.
// Assumes it is bound into bfc_host and sees only its ports.
`default_nettype none
module bfc_host_chk
  import bfc_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic [17:0] FLASH_ADDR,
  input wire logic [7:0]  FLASH_DQ_OUT,
  input wire logic        FLASH_DQ_OE,
  input wire logic        FLASH_CE_N,
  input wire logic        FLASH_OE_N,
  input wire logic        FLASH_WE_N,
  input wire logic        FLASH_PDWN_N,
  input wire logic        FLASH_VPP_HIGH,
  input wire logic        FLASH_HV_ID
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  a_we_selected: assert property (
    !FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N && FLASH_DQ_OE)
    else $error("write strobe without select or data drive");
  a_we_width: assert property (
    $fell(FLASH_WE_N) |-> !FLASH_WE_N [*5] ##1 FLASH_WE_N)
    else $error("write strobe width wrong");
  a_write_latch: assert property (
    $rose(FLASH_WE_N) |-> $stable(FLASH_ADDR) && $stable(FLASH_DQ_OUT)
      && !FLASH_CE_N && FLASH_DQ_OE)
    else $error("address or data moved at strobe rise");
  a_supply_write: assert property (
    $fell(FLASH_WE_N) |-> FLASH_VPP_HIGH)
    else $error("command written with supply low");
  a_read_pins: assert property (
    !FLASH_OE_N |-> !FLASH_CE_N && FLASH_WE_N && !FLASH_DQ_OE && FLASH_PDWN_N)
    else $error("read with wrong pin levels");
  a_select_gap: assert property (
    $rose(FLASH_CE_N) |=> FLASH_CE_N)
    else $error("select high for less than two cycles");
  a_hv_addr: assert property (
    FLASH_HV_ID && !FLASH_OE_N |-> FLASH_ADDR[17:1] == 17'h0_0000)
    else $error("high voltage read with other lines set");
  a_sleep_idle: assert property (
    !FLASH_PDWN_N |-> FLASH_CE_N && !FLASH_HV_ID)
    else $error("access during power down");
  c_confirm: cover property ($fell(FLASH_WE_N) && FLASH_DQ_OUT == CMD_CONFIRM);
  c_hv_read: cover property (FLASH_HV_ID && !FLASH_OE_N);
  c_sleep: cover property ($fell(FLASH_PDWN_N));
endmodule
bind bfc_host bfc_host_chk chk (.CLOCK(CLOCK), .RESET(RESET),
  .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_OUT(FLASH_DQ_OUT),
  .FLASH_DQ_OE(FLASH_DQ_OE), .FLASH_CE_N(FLASH_CE_N),
  .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N),
  .FLASH_PDWN_N(FLASH_PDWN_N), .FLASH_VPP_HIGH(FLASH_VPP_HIGH),
  .FLASH_HV_ID(FLASH_HV_ID));
`default_nettype wire
